// [src/cei_dlv.sv]
// Per-processor vector entry and interrupt delivery unit
`timescale 1ns/1ps
`include "cei_regs.svh"
module cei_dlv import cei_pkg::*; (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Register writes from the interrupt unit port
    input  wire logic        wr_en,
    input  wire logic [11:0] wr_addr,
    input  wire logic [31:0] wr_data,
    // Raise request and acceptance
    input  wire logic        raise,
    input  wire logic        ack,
    // Register images
    output logic      [31:0] entry_q,
    output logic      [31:0] esr_q,
    // Delivery toward the core
    output logic             int_req,
    output logic      [7:0]  int_vec,
    output logic             smi_pulse,
    output logic             nmi_pulse
);
    logic [7:0]     vec;
    cei_mode_t      mode;
    logic           mask;
    logic           illvec;
    cei_dlv_state_t state;
    logic           ent_wr;
    logic           esr_wr;
    logic           take;
    logic           vec_bad;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    assign ent_wr  = wr_en && (wr_addr == `CEI_VEC_OFF);
    assign esr_wr  = wr_en && (wr_addr == `CEI_ESR_OFF);
    assign take    = raise && !mask;
    assign vec_bad = vec < `CEI_VEC_MIN;

    // Entry fields; reserved bits are not stored at all
    always_ff @(posedge clk) begin
        if (!nrst) begin
            vec  <= 8'h00;
            mode <= `CEI_MODE_FIXED;
            mask <= 1'b1;
        end else if (ce && ent_wr) begin
            vec  <= wr_data[`CEI_VEC_MSB:0];
            mode <= wr_data[`CEI_MODE_MSB:`CEI_MODE_LSB];
            mask <= wr_data[`CEI_MASK_BIT];
        end
    end

    // Illegal vector log; a new error wins over the clearing write
    always_ff @(posedge clk) begin
        if (!nrst) begin
            illvec <= 1'b0;
        end else if (ce) begin
            if (esr_wr)
                illvec <= 1'b0;
            if ((ent_wr && wr_data[`CEI_VEC_MSB:0] < `CEI_VEC_MIN &&
                 wr_data[`CEI_MODE_MSB:`CEI_MODE_LSB] == `CEI_MODE_FIXED) ||
                (take && mode == `CEI_MODE_FIXED && vec_bad))
                illvec <= 1'b1;
        end
    end

    // Fixed delivery holds until the core accepts it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state   <= CEI_IDLE;
            int_vec <= 8'h00;
        end else if (ce) begin
            case (state)
                CEI_IDLE: begin
                    if (take && mode == `CEI_MODE_FIXED && !vec_bad) begin
                        state   <= CEI_PEND;
                        int_vec <= vec;
                    end
                end
                CEI_PEND: begin
                    if (ack)
                        state <= CEI_IDLE;
                end
                default: state <= CEI_IDLE;
            endcase
        end
    end

    // Side-band paths; the vector plays no part here
    always_ff @(posedge clk) begin
        if (!nrst) begin
            smi_pulse <= 1'b0;
            nmi_pulse <= 1'b0;
        end else if (ce) begin
            smi_pulse <= take && mode == `CEI_MODE_SMI;
            nmi_pulse <= take && mode == `CEI_MODE_NMI;
        end
    end

    // Other mode codes, init and external among them, do nothing
    assign int_req = (state == CEI_PEND);
    assign entry_q = {15'h0000, mask, 3'h0, int_req, 1'b0, mode, vec};
    assign esr_q   = {25'h0000000, illvec, 6'h00};

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_mask_blocks: assert property (@(posedge clk) disable iff (!nrst)
        ce && raise && mask && !int_req |=> !int_req && !smi_pulse &&
        !nmi_pulse) else $error("masked raise was delivered");
    a_nmi_path: assert property (@(posedge clk) disable iff (!nrst)
        ce && take && mode == `CEI_MODE_NMI |=> nmi_pulse && !smi_pulse)
        else $error("nmi mode raise gave no nmi pulse");
    a_reserved_quiet: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && take && (mode == `CEI_MODE_INIT || mode == `CEI_MODE_EXT)
        && !int_req |=> !int_req && !smi_pulse && !nmi_pulse)
        else $error("unsupported mode delivered");
    a_dstat_hold: assert property (@(posedge clk) disable iff (!nrst)
        int_req && !(ce && ack) |=> int_req && entry_q[`CEI_DSTAT_BIT])
        else $error("delivery status dropped before accept");
endmodule // cei_dlv

// [src/cei_pkg.sv]
// Types shared by the corrected-error interrupt block
package cei_pkg;
    typedef logic [2:0] cei_mode_t;
    typedef logic [14:0] cei_cnt_t;
    typedef enum logic {CEI_IDLE, CEI_PEND} cei_dlv_state_t;
endpackage

// [src/cei_regs.svh]
// Register offsets, field positions and codes of the corrected-error block
`ifndef CEI_REGS_SVH
`define CEI_REGS_SVH

// ---------------------------------------------------------------
// Interrupt unit register space
// ---------------------------------------------------------------
`define CEI_VEC_OFF        12'h2F0
`define CEI_ESR_OFF        12'h280
`define CEI_ESR_ILLVEC_BIT 6
`define CEI_VEC_RESET      32'h0001_0000
`define CEI_VEC_MSB        7
`define CEI_MODE_LSB       8
`define CEI_MODE_MSB       10
`define CEI_DSTAT_BIT      12
`define CEI_MASK_BIT       16
`define CEI_VEC_MIN        8'h10
`define CEI_MODE_FIXED     3'h0
`define CEI_MODE_SMI       3'h2
`define CEI_MODE_NMI       3'h4
`define CEI_MODE_INIT      3'h5
`define CEI_MODE_EXT       3'h7

// ---------------------------------------------------------------
// Bank register space
// ---------------------------------------------------------------
`define CEI_SEL_CTL2       2'h0
`define CEI_SEL_STATUS     2'h1
`define CEI_SEL_CAP        2'h2
`define CEI_CTL2_EN_BIT    30
`define CEI_THR_MSB        15
`define CEI_THR_PROBE      16'h7FFF
`define CEI_STAT_VALID_BIT 63
`define CEI_CNT_LSB        38
`define CEI_CNT_MSB        52
`define CEI_CAP_CNT_MSB    7
`define CEI_CAP_CORRECTED_ERROR_INTERRUPT_BIT   10

`endif

// [src/cei_top.sv]
// Corrected-error threshold banks and interrupt signalling top level
//
// Notes on behaviour
// - Vector entry sits at offset 2F0H
// - Shared-structure errors reach every affected processor
// - Package errors may reach all; system ignored
// - Vector 7:0; below 16 in fixed mode logs illegal vector
// - Mode 000B delivers the programmed vector
// - Mode 010B uses system-management path
// - Mode 100B raises non-maskable, ignores vector
// - Init and external modes unsupported; others reserved
// - Bit 12 shows delivered, not yet accepted
// - Mask bit 16 inhibits; never set by hardware
// - Mask bit set after reset
// - Bits 31:17, 15:13, 11 reserved
// - Enable bit 30 sticks only if supported
// - Enable bit visible to all sharing processors
// - Threshold 15:0 writable; compared against count
// - Threshold one fires on every error
// - Probe 7FFFH reads back supported maximum
// - Capability 7:0 gives the bank count
// - Status bit 63 flags log; software clears
// - Signalling off after reset, enabled per bank
// - Independent of global and per-bank report enables
// - Capability bit 10 shows signalling exists
`timescale 1ns/1ps
`include "cei_regs.svh"
module cei_top import cei_pkg::*; #(
    parameter int                   NUM_BANKS = 4,
    parameter int                   NUM_LP    = 2,
    parameter int                   THR_BITS  = 15,
    parameter logic [NUM_BANKS-1:0] BANK_CORRECTED_ERROR_INTERRUPT = '1,
    parameter int                   LPW = (NUM_LP > 1) ? $clog2(NUM_LP) : 1,
    parameter int                   BW = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1
) (
    // Clock, reset, enable
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                ce,
    // Interrupt unit register port
    input  wire logic                unit_wr,
    input  wire logic                unit_rd,
    input  wire logic [LPW-1:0]      unit_lp,
    input  wire logic [11:0]         unit_addr,
    input  wire logic [31:0]         unit_wdata,
    output logic      [31:0]         unit_rdata,
    // Bank register port, shared by all processors
    input  wire logic                bank_wr,
    input  wire logic                bank_rd,
    input  wire logic [1:0]          bank_sel,
    input  wire logic [BW-1:0]       bank_idx,
    input  wire logic [63:0]         bank_wdata,
    output logic      [63:0]         bank_rdata,
    // Corrected error events
    input  wire logic                err_valid,
    input  wire logic [BW-1:0]       err_bank,
    input  wire logic [NUM_LP-1:0]   err_lp_mask,
    input  wire logic                err_pkg,
    input  wire logic                err_sys,
    // Delivery toward the cores
    output logic      [NUM_LP-1:0]   int_req,
    output logic      [8*NUM_LP-1:0] int_vec,
    input  wire logic [NUM_LP-1:0]   int_ack,
    output logic      [NUM_LP-1:0]   smi_req,
    output logic      [NUM_LP-1:0]   nmi_req
);
    localparam logic [14:0] THR_MAX = 15'((1 << THR_BITS) - 1);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Threshold as the comparator sees it, clipped to what is built
    function automatic logic [14:0] thr_clip(input logic [15:0] t);
        if (t[14:0] > THR_MAX)
            thr_clip = THR_MAX;
        else
            thr_clip = t[14:0];
    endfunction

    // Saturating count step, so a flood never wraps to small values
    function automatic cei_cnt_t cnt_step(input cei_cnt_t c);
        if (c == 15'h7FFF)
            cnt_step = c;
        else
            cnt_step = 15'(c + 15'h0001);
    endfunction

    logic [15:0]       thr   [NUM_BANKS];
    logic              en    [NUM_BANKS];
    logic              valid [NUM_BANKS];
    cei_cnt_t          cnt   [NUM_BANKS];
    logic [31:0]       ent_q [NUM_LP];
    logic [31:0]       esr_q [NUM_LP];
    logic              bank_ok;
    logic              ev_ok;
    cei_cnt_t          next_cnt;
    logic              hit;
    logic [NUM_LP-1:0] next_raise;
    logic [NUM_LP-1:0] raise_q;

    // ---------------------------------------------------------------
    // Event qualification
    // ---------------------------------------------------------------
    // System-level errors never enter this path
    assign bank_ok  = 32'(bank_idx) < NUM_BANKS;
    assign ev_ok    = err_valid && !err_sys &&
                      32'(err_bank) < NUM_BANKS;
    assign next_cnt = cnt_step(cnt[err_bank]);
    // Count is compared with >= so a lowered threshold still fires
    assign hit      = ev_ok && en[err_bank] &&
                      thr_clip(thr[err_bank]) != 15'h0000 &&
                      next_cnt >= thr_clip(thr[err_bank]);
    // Package errors fan out to every processor in the package
    always_comb begin
        next_raise = '0;
        if (hit && err_pkg)
            next_raise = '1;
        else if (hit)
            next_raise = err_lp_mask;
    end

    // One registered raise per crossing event
    always_ff @(posedge clk) begin
        if (!nrst) begin
            raise_q <= '0;
        end else if (ce) begin
            raise_q <= next_raise;
        end
    end

    // ---------------------------------------------------------------
    // Bank control: threshold and enable, one copy for all threads
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                thr[b] <= 16'h0000;
                en[b]  <= 1'b0;
            end
        end else if (ce && bank_wr && bank_ok &&
                     bank_sel == `CEI_SEL_CTL2) begin
            thr[bank_idx] <= bank_wdata[`CEI_THR_MSB:0];
            // Enable only sticks where the bank can signal
            en[bank_idx]  <= bank_wdata[`CEI_CTL2_EN_BIT] &&
                             BANK_CORRECTED_ERROR_INTERRUPT[bank_idx];
        end
    end

    // ---------------------------------------------------------------
    // Bank status: valid flag and corrected count
    // ---------------------------------------------------------------
    // Software write first, hardware event last, so the event wins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                valid[b] <= 1'b0;
                cnt[b]   <= 15'h0000;
            end
        end else if (ce) begin
            if (bank_wr && bank_ok && bank_sel == `CEI_SEL_STATUS) begin
                valid[bank_idx] <= bank_wdata[`CEI_STAT_VALID_BIT];
                cnt[bank_idx]   <= bank_wdata[`CEI_CNT_MSB:`CEI_CNT_LSB];
            end
            if (ev_ok) begin
                valid[err_bank] <= 1'b1;
                cnt[err_bank]   <= next_cnt;
            end
        end
    end

    // ---------------------------------------------------------------
    // Bank read data, registered
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bank_rdata <= 64'h0;
        end else if (ce && bank_rd) begin
            case (bank_sel)
                `CEI_SEL_CTL2: begin
                    bank_rdata <= !bank_ok ? 64'h0 :
                        {33'h0, en[bank_idx], 14'h0,
                         thr[bank_idx][15],
                         thr_clip(thr[bank_idx])};
                end
                `CEI_SEL_STATUS: begin
                    bank_rdata <= !bank_ok ? 64'h0 :
                        {valid[bank_idx], 10'h0,
                         cnt[bank_idx], 38'h0};
                end
                `CEI_SEL_CAP: begin
                    bank_rdata <= {53'h0, |BANK_CORRECTED_ERROR_INTERRUPT,
                                   2'h0, 8'(NUM_BANKS)};
                end
                default: bank_rdata <= 64'h0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Per-processor delivery units
    // ---------------------------------------------------------------
    for (genvar i = 0; i < NUM_LP; i++) begin : g_lp
        cei_dlv u_dlv (
            .clk       (clk),
            .nrst      (nrst),
            .ce        (ce),
            .wr_en     (unit_wr && unit_lp == LPW'(i)),
            .wr_addr   (unit_addr),
            .wr_data   (unit_wdata),
            .raise     (raise_q[i]),
            .ack       (int_ack[i]),
            .entry_q   (ent_q[i]),
            .esr_q     (esr_q[i]),
            .int_req   (int_req[i]),
            .int_vec   (int_vec[8*i +: 8]),
            .smi_pulse (smi_req[i]),
            .nmi_pulse (nmi_req[i])
        );
    end

    // ---------------------------------------------------------------
    // Interrupt unit read data, registered
    // ---------------------------------------------------------------
    // A processor index beyond the built ones reads as zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            unit_rdata <= 32'h0;
        end else if (ce && unit_rd) begin
            if (32'(unit_lp) >= NUM_LP)
                unit_rdata <= 32'h0;
            else if (unit_addr == `CEI_VEC_OFF)
                unit_rdata <= ent_q[unit_lp];
            else if (unit_addr == `CEI_ESR_OFF)
                unit_rdata <= esr_q[unit_lp];
            else
                unit_rdata <= 32'h0;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // Event path: counting, fan-out and raise
    a_thr_one_fires: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && ev_ok && en[err_bank] && thr[err_bank] == 16'h0001 &&
        (err_pkg || err_lp_mask != '0) |=> raise_q != '0)
        else $error("threshold one did not fire");

    a_sys_ignored: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && err_valid && err_sys |=> raise_q == '0)
        else $error("system error raised an interrupt");

    a_pkg_fanout: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && hit && err_pkg |=> raise_q == {NUM_LP{1'b1}})
        else $error("package error not sent to all");

    a_shared_fanout: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && hit && !err_pkg |=> raise_q == $past(err_lp_mask))
        else $error("raise did not follow affected mask");

    a_disabled_quiet: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && ev_ok && !en[err_bank] |=> raise_q == '0)
        else $error("disabled bank raised an interrupt");

    a_raise_single: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && !hit |=> raise_q == '0)
        else $error("raise without a crossing event");

    a_valid_set: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && ev_ok |=> valid[$past(err_bank)])
        else $error("logged error left valid clear");

    // Register path: bank reads and writes, unit reads
    a_cap_count: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && bank_rd && bank_sel == `CEI_SEL_CAP |=>
        bank_rdata[`CEI_CAP_CNT_MSB:0] == 8'(NUM_BANKS) &&
        bank_rdata[`CEI_CAP_CORRECTED_ERROR_INTERRUPT_BIT] == |BANK_CORRECTED_ERROR_INTERRUPT)
        else $error("capability read wrong");

    a_en_unsupported: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && bank_wr && bank_ok && bank_sel == `CEI_SEL_CTL2 &&
        !BANK_CORRECTED_ERROR_INTERRUPT[bank_idx] |=> !en[$past(bank_idx)])
        else $error("enable stuck on unsupported bank");

    a_ctl2_write: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && bank_wr && bank_ok && bank_sel == `CEI_SEL_CTL2 |=>
        thr[$past(bank_idx)] == $past(bank_wdata[`CEI_THR_MSB:0]))
        else $error("threshold write not stored");

    a_probe_clip: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && bank_rd && bank_sel == `CEI_SEL_CTL2 |=>
        bank_rdata[14:0] <= THR_MAX)
        else $error("threshold read above built maximum");

    a_status_clear: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && bank_wr && bank_ok && bank_sel == `CEI_SEL_STATUS &&
        !bank_wdata[`CEI_STAT_VALID_BIT] && !ev_ok |=>
        !valid[$past(bank_idx)])
        else $error("status clear left valid set");

    a_unit_unmapped: assert property (@(posedge clk)
        disable iff (!nrst)
        ce && unit_rd && unit_addr != `CEI_VEC_OFF &&
        unit_addr != `CEI_ESR_OFF |=> unit_rdata == 32'h0)
        else $error("unmapped offset read nonzero");
endmodule // cei_top

// [verification/cei_core_model.sv]
// Core-side model that accepts fixed-mode requests after a set delay
`timescale 1ns/1ps
module cei_core_model #(
    parameter int NUM_LP = 2
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // Request, acceptance delay and acceptance
    input  wire logic [NUM_LP-1:0] int_req,
    input  wire logic [7:0]        dly,
    output logic      [NUM_LP-1:0] int_ack
);
    logic [7:0] wait_cnt [NUM_LP];

    // Accept after dly cycles; a slow core keeps the request pending
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_LP; i++) begin
            if (!nrst || !int_req[i] || int_ack[i]) begin
                int_ack[i]  <= 1'b0;
                wait_cnt[i] <= 8'h00;
            end else if (wait_cnt[i] >= dly) begin
                int_ack[i] <= 1'b1;
            end else begin
                wait_cnt[i] <= wait_cnt[i] + 8'h01;
            end
        end
    end
endmodule // cei_core_model

// [verification/cei_top_tb.sv]
// Self-checking bench for the corrected-error interrupt top level
`timescale 1ns/1ps
`include "cei_regs.svh"
module cei_top_tb;
    // ------------------------------------------------------------
    // Signals, mode table and counters
    // ------------------------------------------------------------
    logic        clk, nrst, ce, unit_wr, unit_rd, unit_lp;
    logic [11:0] unit_addr;
    logic [31:0] unit_wdata, unit_rdata;
    logic        bank_wr, bank_rd, err_valid, err_pkg, err_sys;
    logic [1:0]  bank_sel, bank_idx, err_bank, err_lp_mask;
    logic [63:0] bank_wdata, bank_rdata;
    logic [1:0]  int_req, int_ack, smi_req, nmi_req;
    logic [15:0] int_vec;
    logic [7:0]  dly;
    int          compares, miscompares;
    typedef struct packed {
        logic [2:0] mode;
        logic [7:0] vec;
        logic [2:0] exp; // Fixed, system-management, non-maskable
    } cei_row_t;
    localparam cei_row_t ROWS [8] = '{
        '{3'h0, 8'h30, 3'h4}, '{3'h2, 8'h00, 3'h2}, '{3'h4, 8'h55, 3'h1},
        '{3'h5, 8'h30, 3'h0}, '{3'h7, 8'h30, 3'h0}, '{3'h1, 8'h30, 3'h0},
        '{3'h3, 8'h30, 3'h0}, '{3'h6, 8'h30, 3'h0}};

    // Bank 3 lacks signalling; a 12-bit comparator shows the probe clip
    cei_top #(.BANK_CORRECTED_ERROR_INTERRUPT(4'b0111), .THR_BITS(12)) DUT (
        .clk(clk), .nrst(nrst), .ce(ce), .unit_wr(unit_wr),
        .unit_rd(unit_rd), .unit_lp(unit_lp), .unit_addr(unit_addr),
        .unit_wdata(unit_wdata), .unit_rdata(unit_rdata),
        .bank_wr(bank_wr), .bank_rd(bank_rd), .bank_sel(bank_sel),
        .bank_idx(bank_idx), .bank_wdata(bank_wdata),
        .bank_rdata(bank_rdata), .err_valid(err_valid),
        .err_bank(err_bank), .err_lp_mask(err_lp_mask),
        .err_pkg(err_pkg), .err_sys(err_sys), .int_req(int_req),
        .int_vec(int_vec), .int_ack(int_ack), .smi_req(smi_req),
        .nmi_req(nmi_req));
    cei_core_model #(.NUM_LP(2)) core (
        .clk(clk), .nrst(nrst), .int_req(int_req), .dly(dly),
        .int_ack(int_ack));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Bus and event tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] a, input logic [63:0] e);
        compares++;
        if (a !== e) begin
            miscompares++;
            $display("ERROR at %0t ns: expected %h, got %h", $time, e, a);
        end
    endtask
    task automatic uwr(input logic lp, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        unit_wr    <= 1'b1;
        unit_lp    <= lp;
        unit_addr  <= a;
        unit_wdata <= d;
        @(posedge clk);
        unit_wr <= 1'b0;
    endtask
    // Read data is registered, so it is taken one edge after the strobe
    task automatic ucheck(input logic lp, input logic [11:0] a,
                          input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        unit_rd   <= 1'b1;
        unit_lp   <= lp;
        unit_addr <= a;
        @(posedge clk);
        unit_rd <= 1'b0;
        #1;
        chk({32'h0, unit_rdata & m}, {32'h0, e});
    endtask
    task automatic bwr(input logic [1:0] s, input logic [1:0] b,
                       input logic [63:0] d);
        @(posedge clk);
        bank_wr    <= 1'b1;
        bank_sel   <= s;
        bank_idx   <= b;
        bank_wdata <= d;
        @(posedge clk);
        bank_wr <= 1'b0;
    endtask
    task automatic bcheck(input logic [1:0] s, input logic [1:0] b,
                          input logic [63:0] m, input logic [63:0] e);
        @(posedge clk);
        bank_rd  <= 1'b1;
        bank_sel <= s;
        bank_idx <= b;
        @(posedge clk);
        bank_rd <= 1'b0;
        #1;
        chk(bank_rdata & m, e);
    endtask
    // One error event; outputs settle one edge after it is taken
    task automatic fire(input logic [1:0] b, input logic [1:0] lpm,
                        input logic pk, input logic sy,
                        input logic [5:0] e, input logic [15:0] v);
        logic [15:0] m;
        m = {{8{e[5]}}, {8{e[4]}}};
        @(posedge clk);
        err_valid   <= 1'b1;
        err_bank    <= b;
        err_lp_mask <= lpm;
        err_pkg     <= pk;
        err_sys     <= sy;
        @(posedge clk);
        err_valid <= 1'b0;
        @(posedge clk);
        #1;
        chk({58'h0, int_req, smi_req, nmi_req}, {58'h0, e});
        chk({48'h0, int_vec & m}, {48'h0, v & m});
        repeat (12) @(posedge clk);
    endtask
    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 470 cycles
    initial begin
        #(40 * 6000);
        miscompares++;
        results();
    end

    // Main sequence
    initial begin
        {ce, unit_wr, unit_rd, unit_lp, bank_wr, bank_rd} = 6'b100000;
        {err_valid, err_pkg, err_sys, bank_sel, bank_idx} = 7'h00;
        {unit_addr, unit_wdata, bank_wdata} = 108'h0;
        {err_bank, err_lp_mask, nrst, compares, miscompares} = 69'h0;
        dly = 8'h03;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        bwr(`CEI_SEL_CTL2, 2'h0, 64'h4000_0001);
        foreach (ROWS[i]) begin
            uwr(1'b0, `CEI_VEC_OFF, {21'h0, ROWS[i].mode, ROWS[i].vec});
            fire(2'h0, 2'h1, 1'b0, 1'b0, {1'b0, ROWS[i].exp[2], 1'b0,
                 ROWS[i].exp[1], 1'b0, ROWS[i].exp[0]},
                 {8'h00, ROWS[i].vec});
        end
        $display("test delivery modes done");
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        ucheck(1'b0, `CEI_VEC_OFF, 32'hFFFF_FFFF, 32'h0001_0000);
        bcheck(`CEI_SEL_CTL2, 2'h0, '1, 64'h0);
        bcheck(`CEI_SEL_CAP, 2'h0, 64'h7FF, 64'h404);
        $display("test reset values done");
        bwr(`CEI_SEL_CTL2, 2'h0, 64'h4000_0001);
        uwr(1'b0, `CEI_VEC_OFF, 32'h0001_0030);
        fire(2'h0, 2'h1, 1'b0, 1'b0, 6'h00, 16'h0);
        uwr(1'b0, `CEI_VEC_OFF, 32'h0000_0030);
        fire(2'h0, 2'h1, 1'b0, 1'b0, 6'h10, 16'h0030);
        ucheck(1'b0, `CEI_VEC_OFF, 32'hFFFF_FFFF, 32'h0000_0030);
        uwr(1'b1, `CEI_VEC_OFF, 32'h0000_0040);
        fire(2'h0, 2'h3, 1'b0, 1'b0, 6'h30, 16'h4030);
        fire(2'h0, 2'h0, 1'b1, 1'b0, 6'h30, 16'h4030);
        fire(2'h0, 2'h3, 1'b0, 1'b1, 6'h00, 16'h0);
        $display("test masking and sharing done");
        bwr(`CEI_SEL_CTL2, 2'h1, 64'h4000_0003);
        fire(2'h1, 2'h1, 1'b0, 1'b0, 6'h00, 16'h0);
        fire(2'h1, 2'h1, 1'b0, 1'b0, 6'h00, 16'h0);
        fire(2'h1, 2'h1, 1'b0, 1'b0, 6'h10, 16'h0030);
        bcheck(`CEI_SEL_STATUS, 2'h1, 64'h801F_FFC0_0000_0000,
               64'h8000_00C0_0000_0000);
        bwr(`CEI_SEL_STATUS, 2'h1, 64'h0);
        bcheck(`CEI_SEL_STATUS, 2'h1, '1, 64'h0);
        $display("test threshold count done");
        bwr(`CEI_SEL_CTL2, 2'h2, 64'h7FFF);
        bcheck(`CEI_SEL_CTL2, 2'h2, '1, 64'h0FFF);
        bwr(`CEI_SEL_CTL2, 2'h2, 64'h4000_7FFF);
        bcheck(`CEI_SEL_CTL2, 2'h2, 64'h4000_0000, 64'h4000_0000);
        bwr(`CEI_SEL_CTL2, 2'h3, 64'h4000_0001);
        bcheck(`CEI_SEL_CTL2, 2'h3, 64'h4000_0000, 64'h0);
        fire(2'h3, 2'h1, 1'b0, 1'b0, 6'h00, 16'h0);
        $display("test bank claim done");
        uwr(1'b0, `CEI_VEC_OFF, 32'hFFFF_FFFF);
        ucheck(1'b0, `CEI_VEC_OFF, '1, 32'h0001_07FF);
        uwr(1'b0, `CEI_VEC_OFF, 32'h0000_0005);
        fire(2'h0, 2'h1, 1'b0, 1'b0, 6'h00, 16'h0);
        ucheck(1'b0, `CEI_ESR_OFF, 32'h40, 32'h40);
        uwr(1'b0, `CEI_ESR_OFF, 32'h0);
        uwr(1'b0, `CEI_VEC_OFF, 32'h0000_0010);
        fire(2'h0, 2'h1, 1'b0, 1'b0, 6'h10, 16'h0010);
        ucheck(1'b0, `CEI_ESR_OFF, 32'h40, 32'h0);
        ucheck(1'b0, 12'h100, '1, 32'h0);
        $display("test vector field done");
        dly <= 8'h28;
        uwr(1'b0, `CEI_VEC_OFF, 32'h0000_0030);
        fire(2'h0, 2'h1, 1'b0, 1'b0, 6'h10, 16'h0030);
        ucheck(1'b0, `CEI_VEC_OFF, '1, 32'h0000_1030);
        repeat (60) @(posedge clk);
        ucheck(1'b0, `CEI_VEC_OFF, '1, 32'h0000_0030);
        $display("test delivery status done");
        @(posedge clk);
        ce <= 1'b0;
        fire(2'h0, 2'h1, 1'b0, 1'b0, 6'h00, 16'h0);
        ce <= 1'b1;
        $display("test clock enable done");
        results();
    end
endmodule // cei_top_tb
